// file: pkg/oscme_pkg.sv
/*
 * Constants for the oscillator manual enable block: register map, bit positions,
 * reset values and the AXI4-Lite response codes.
 * Assumes a single 125 MHz clock and a 32-bit AXI4-Lite register bus.
 */
// Function
// (R1) Bit 7 set keeps external oscillator running in its mode, any clock selection.
// (R2) Bit 6 set keeps fast internal oscillator running at selected frequency.
// (R3) Clearing a bit only withdraws software request; enable is OR of requests.
// (R4) Bit 5 set keeps medium internal oscillator enabled regardless of others.
// (R5) Bits 4..2 force slow, secondary, RC on; bits 1..0 read zero; reset clears.
// (R6) Each source reports read-only ready flag: enabled and stable, else zero.
package oscme_pkg;

    localparam int          OSCME_NSRC        = 6;
    localparam logic [11:0] OSCME_ADDR_ENABLE = 12'h000;
    localparam logic [11:0] OSCME_ADDR_READY  = 12'h004;

    // Source index is the bit position inside both registers, lowest is bit 2
    localparam int          OSCME_SRC_LSB     = 2;
    localparam int          OSCME_BIT_EXT     = 7;
    localparam int          OSCME_BIT_FAST    = 6;
    localparam int          OSCME_BIT_MED     = 5;
    localparam int          OSCME_BIT_SLOW    = 4;
    localparam int          OSCME_BIT_SEC     = 3;
    localparam int          OSCME_BIT_RC      = 2;

    localparam logic [7:0]  OSCME_ENABLE_RST  = 8'h00;
    localparam logic [7:0]  OSCME_WRITE_MASK  = 8'hFC;

    localparam logic [1:0]  OSCME_RESP_OKAY   = 2'h0;
    localparam logic [1:0]  OSCME_RESP_SLVERR = 2'h2;

endpackage : oscme_pkg

// file: design/oscme_top.sv
/*
 * Oscillator manual enable block: the software force-on register, the
 * per-source enable that ORs it with every other requester, and the
 * read-only ready flags; the register and the flags are reached over an AXI4-Lite slave.
 * Assumes the other requesters' enables are synchronous to aclk, the
 * oscillator stable indications arrive from their own clock domains, and
 * clk_en is driven from logic on aclk.
 */
`timescale 1ns/10ps
module oscme_top
    import oscme_pkg::*;
(
    input  wire logic                  aclk,
    input  wire logic                  aresetn,
    input  wire logic                  clk_en,
    input  wire logic [11:0]           s_axi_awaddr,
    input  wire logic                  s_axi_awvalid,
    output logic                       s_axi_awready,
    input  wire logic [31:0]           s_axi_wdata,
    input  wire logic [3:0]            s_axi_wstrb,
    input  wire logic                  s_axi_wvalid,
    output logic                       s_axi_wready,
    output logic [1:0]                 s_axi_bresp,
    output logic                       s_axi_bvalid,
    input  wire logic                  s_axi_bready,
    input  wire logic [11:0]           s_axi_araddr,
    input  wire logic                  s_axi_arvalid,
    output logic                       s_axi_arready,
    output logic [31:0]                s_axi_rdata,
    output logic [1:0]                 s_axi_rresp,
    output logic                       s_axi_rvalid,
    input  wire logic                  s_axi_rready,
    input  wire logic [7:0]            other_osc_request,
    input  wire logic [7:0]            osc_stable,
    output logic [7:0]                 osc_enable
);

    // Software register
    logic [7:0]  enable_q;
    logic [7:0]  enable_d;

    // Write channel: halves of a write held until the other half arrives
    logic        aw_q;
    logic        aw_d;
    logic        w_q;
    logic        w_d;
    logic [11:0] awaddr_q;
    logic [11:0] awaddr_d;
    logic [31:0] wdata_q;
    logic [31:0] wdata_d;
    logic [3:0]  wstrb_q;
    logic [3:0]  wstrb_d;
    logic        bvalid_q;
    logic        bvalid_d;
    logic [1:0]  bresp_q;
    logic [1:0]  bresp_d;

    // Read channel
    logic        rvalid_q;
    logic        rvalid_d;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic [1:0]  rresp_q;
    logic [1:0]  rresp_d;

    // Source path: synchroniser, ready flags and combined enables
    logic [7:0]  stable_meta_q;
    logic [7:0]  stable_sync_q;
    logic [7:0]  ready_q;
    logic [7:0]  ready_d;
    logic [7:0]  osc_enable_q;
    logic [7:0]  osc_enable_d;

    // A waiting response blocks both write channels, so one write at most is in flight
    assign s_axi_awready = ~aw_q & ~bvalid_q;
    assign s_axi_wready  = ~w_q & ~bvalid_q;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;

    // One read in flight: a new address waits until the data has been taken
    assign s_axi_arready = ~rvalid_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rdata   = rdata_q;
    assign s_axi_rresp   = rresp_q;

    assign osc_enable    = osc_enable_q;

    // Bus slave: address and data latched in any order, response after both
    always_comb begin
        logic        have_aw;
        logic        have_w;
        logic [11:0] wa;
        logic [31:0] wd;
        logic [3:0]  ws;
        // A half taken in this cycle counts as held
        have_aw  = aw_q | (s_axi_awvalid & s_axi_awready);
        have_w   = w_q | (s_axi_wvalid & s_axi_wready);
        wa       = aw_q ? awaddr_q : s_axi_awaddr;
        wd       = w_q ? wdata_q : s_axi_wdata;
        ws       = w_q ? wstrb_q : s_axi_wstrb;
        aw_d     = aw_q;
        w_d      = w_q;
        awaddr_d = awaddr_q;
        wdata_d  = wdata_q;
        wstrb_d  = wstrb_q;
        bvalid_d = bvalid_q & ~s_axi_bready;
        bresp_d  = bresp_q;
        enable_d = enable_q;
        if (have_aw & have_w) begin
            aw_d     = 1'b0;
            w_d      = 1'b0;
            bvalid_d = 1'b1;
            bresp_d  = OSCME_RESP_OKAY;
            if (wa[11:2] == OSCME_ADDR_ENABLE[11:2]) begin
                // Only byte lane 0 carries the register
                // (R5) Low bits unwritable
                if (ws[0]) begin
                    enable_d = wd[7:0] & OSCME_WRITE_MASK;
                end
            end else if (wa[11:2] != OSCME_ADDR_READY[11:2]) begin
                bresp_d = OSCME_RESP_SLVERR;
            end
        end else begin
            if (s_axi_awvalid & s_axi_awready) begin
                aw_d     = 1'b1;
                awaddr_d = s_axi_awaddr;
            end
            if (s_axi_wvalid & s_axi_wready) begin
                w_d     = 1'b1;
                wdata_d = s_axi_wdata;
                wstrb_d = s_axi_wstrb;
            end
        end
    end

    always_comb begin
        rvalid_d = rvalid_q & ~s_axi_rready;
        rdata_d  = rdata_q;
        rresp_d  = rresp_q;
        if (s_axi_arvalid & s_axi_arready) begin
            rvalid_d = 1'b1;
            rresp_d  = OSCME_RESP_OKAY;
            // Upper bits always read as zero
            rdata_d  = 32'h0000_0000;
            if (s_axi_araddr[11:2] == OSCME_ADDR_ENABLE[11:2]) begin
                rdata_d[7:0] = enable_q;
            end else if (s_axi_araddr[11:2] == OSCME_ADDR_READY[11:2]) begin
                // (R6) Ready flags read-only
                rdata_d[7:0] = ready_q;
            end else begin
                rresp_d = OSCME_RESP_SLVERR;
            end
        end
    end

    // Per-source enable and ready, one slice per oscillator bit
    // A stable input alone never reads ready; the flag also needs this block's enable
    for (genvar i = 0; i < 8; i++) begin : g_src
        if (i >= OSCME_SRC_LSB) begin : g_impl
            // (R1) (R2) (R4) (R5) (R3) OR of requests
            assign osc_enable_d[i] = enable_q[i] | other_osc_request[i];
            // (R6) Ready only when enabled and stable
            assign ready_d[i]      = osc_enable_q[i] & stable_sync_q[i];
        end else begin : g_none
            // (R5) No source here
            assign osc_enable_d[i] = 1'b0;
            assign ready_d[i]      = 1'b0;
        end
    end

    // Write channel and software register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            // (R5) Cleared on reset
            enable_q <= OSCME_ENABLE_RST;
            aw_q     <= 1'b0;
            w_q      <= 1'b0;
            awaddr_q <= 12'h000;
            wdata_q  <= 32'h0000_0000;
            wstrb_q  <= 4'h0;
            bvalid_q <= 1'b0;
            bresp_q  <= OSCME_RESP_OKAY;
        end else if (clk_en) begin
            enable_q <= enable_d;
            aw_q     <= aw_d;
            w_q      <= w_d;
            awaddr_q <= awaddr_d;
            wdata_q  <= wdata_d;
            wstrb_q  <= wstrb_d;
            bvalid_q <= bvalid_d;
            bresp_q  <= bresp_d;
        end
    end

    // Read channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rdata_q  <= 32'h0000_0000;
            rresp_q  <= OSCME_RESP_OKAY;
        end else if (clk_en) begin
            rvalid_q <= rvalid_d;
            rdata_q  <= rdata_d;
            rresp_q  <= rresp_d;
        end
    end

    // Source path; enables are registered so the oscillator gates never see a glitch
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            stable_meta_q <= 8'h00;
            stable_sync_q <= 8'h00;
            ready_q       <= 8'h00;
            osc_enable_q  <= 8'h00;
        end else if (clk_en) begin
            // Stable indications come from the oscillators' own domains
            stable_meta_q <= osc_stable;
            stable_sync_q <= stable_meta_q;
            ready_q       <= ready_d;
            osc_enable_q  <= osc_enable_d;
        end
    end

endmodule : oscme_top

// file: dv/oscme_top_asserts.sv
/* Checker on the oscme_top ports.
   Assumes clk_en is held high by the bench. */
`timescale 1ns/10ps
module oscme_chk
    import oscme_pkg::*;
(
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [7:0]  other_osc_request,
    input wire logic [7:0]  osc_enable
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence s_ar_taken; s_axi_arvalid && s_axi_arready; endsequence
    sequence s_r_stall; s_axi_rvalid && !s_axi_rready; endsequence
    a_read_answer: assert property (s_ar_taken |=> s_axi_rvalid) else $error("read not answered");
    a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("address taken while busy");
    a_r_hold: assert property (s_r_stall |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
    a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("response dropped");
    a_rdata_unused: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000 && !s_axi_rdata[1:0])
        else $error("unused read bits set");
    a_low_zero: assert property (osc_enable[1:0] == 2'h0) else $error("low enable bits set");
    // Any other requester keeps the source on
    a_other_or: assert property (1'b1 |=> &(osc_enable[7:2] | ~$past(other_osc_request[7:2])))
        else $error("other request not honoured");
    a_reset_clear: assert property (disable iff (1'b0) !aresetn |=> osc_enable == 8'h00)
        else $error("enable not cleared by reset");
endmodule : oscme_chk
bind oscme_top oscme_chk oscme_chk_inst (.aclk(aclk), .aresetn(aresetn), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .s_axi_rdata(s_axi_rdata), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .other_osc_request(other_osc_request), .osc_enable(osc_enable));

// file: dv/test_oscme_top.sv
/* Register-level bench for oscme_top over AXI4-Lite.
   Assumes the package, design and checker are compiled first. */
`timescale 1ns/10ps
module test_oscme_top
    import oscme_pkg::*;
;
    logic aclk = 0, aresetn = 0, clk_en = 1, awv = 0, wv = 0, brdy = 0, arv = 0, rrdy = 0;
    logic awr, wr_r, bv, arr, rv;
    logic [11:0] awa = 12'h000, ara = 12'h000;
    logic [31:0] wd = 32'h0000_0000, rd_d;
    logic [3:0]  ws = 4'h0;
    logic [1:0]  br, rr;
    logic [7:0]  oth = 8'h00, stb = 8'h00, en;
    int num_errors = 0, total_checks = 0;
    // Cycles the master waits before raising bready or rready, to stall the answer
    int lag = 0;
    always #4 aclk = ~aclk;
    oscme_top oscme_top_inst (.aclk(aclk), .aresetn(aresetn), .clk_en(clk_en), .s_axi_awaddr(awa),
        .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv),
        .s_axi_wready(wr_r), .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(brdy), .s_axi_araddr(ara),
        .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd_d), .s_axi_rresp(rr), .s_axi_rvalid(rv),
        .s_axi_rready(rrdy), .other_osc_request(oth), .osc_stable(stb), .osc_enable(en));
    task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask : check
    task automatic print_verdict;
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : print_verdict
    // Flags are sampled at the falling edge, where they equal what the next rising edge sees
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
        logic ta, tw, tb;
        int   n;
        n = 0;
        awa <= a;
        wd <= d;
        ws <= s;
        awv <= 1'b1;
        wv <= 1'b1;
        brdy <= (lag == 0);
        do begin
            @(negedge aclk);
            ta = awv && awr;
            tw = wv && wr_r;
            tb = bv && brdy;
            if (tb)
                check("bresp", br, er);
            @(posedge aclk);
            n++;
            if (ta)
                awv <= 1'b0;
            if (tw)
                wv <= 1'b0;
            if (!tb && n >= lag)
                brdy <= 1'b1;
        end while (!tb);
        brdy <= 1'b0;
        @(posedge aclk);
    endtask : wr
    task automatic rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
        logic ta, tr;
        int   n;
        n = 0;
        ara <= a;
        arv <= 1'b1;
        rrdy <= (lag == 0);
        do begin
            @(negedge aclk);
            ta = arv && arr;
            tr = rv && rrdy;
            if (tr)
                check("rresp", rr, er);
            if (tr && er === OSCME_RESP_OKAY)
                check("rdata", rd_d, ed);
            @(posedge aclk);
            n++;
            if (ta)
                arv <= 1'b0;
            if (!tr && n >= lag)
                rrdy <= 1'b1;
        end while (!tr);
        rrdy <= 1'b0;
        @(posedge aclk);
    endtask : rd
    initial begin
        #20000;
        num_errors++;
        print_verdict();
    end
    initial begin
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        rd(OSCME_ADDR_ENABLE, 32'h0000_0000, OSCME_RESP_OKAY);
        for (int b = 2; b < 8; b++) begin
            wr(OSCME_ADDR_ENABLE, 32'h0000_0003 | (32'h0000_0001 << b), 4'h1, OSCME_RESP_OKAY);
            rd(OSCME_ADDR_ENABLE, 32'h0000_0001 << b, OSCME_RESP_OKAY);
            check("osc_enable", {24'h00_0000, en}, 32'h0000_0001 << b);
        end
        oth <= 8'h90;
        wr(OSCME_ADDR_ENABLE, 32'h0000_0044, 4'h1, OSCME_RESP_OKAY);
        stb <= 8'hFF;
        repeat (6) @(posedge aclk);
        rd(OSCME_ADDR_READY, 32'h0000_00D4, OSCME_RESP_OKAY);
        wr(OSCME_ADDR_ENABLE, 32'h0000_0000, 4'h1, OSCME_RESP_OKAY);
        check("osc_enable", {24'h00_0000, en}, 32'h0000_0090);
        stb <= 8'h10;
        repeat (6) @(posedge aclk);
        lag = 3;
        rd(OSCME_ADDR_READY, 32'h0000_0010, OSCME_RESP_OKAY);
        wr(12'h008, 32'h0000_00FF, 4'h1, OSCME_RESP_SLVERR);
        lag = 0;
        rd(12'h008, 32'h0000_0000, OSCME_RESP_SLVERR);
        wr(OSCME_ADDR_ENABLE, 32'h0000_00FC, 4'h0, OSCME_RESP_OKAY);
        wr(OSCME_ADDR_READY, 32'h0000_00FC, 4'h1, OSCME_RESP_OKAY);
        rd(OSCME_ADDR_READY, 32'h0000_0010, OSCME_RESP_OKAY);
        rd(OSCME_ADDR_ENABLE, 32'h0000_0000, OSCME_RESP_OKAY);
        // Reset in mid-run clears the register although another requester stays active
        wr(OSCME_ADDR_ENABLE, 32'h0000_00FC, 4'h1, OSCME_RESP_OKAY);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        check("osc_enable", {24'h00_0000, en}, 32'h0000_0000);
        rd(OSCME_ADDR_ENABLE, 32'h0000_0000, OSCME_RESP_OKAY);
        check("osc_enable", {24'h00_0000, en}, 32'h0000_0090);
        print_verdict();
    end
endmodule : test_oscme_top
